// file: sp_pkg.sv
/*
 Shared constants, types and helper functions of the serial port block.
 Assumes one 20 MHz system clock and byte addressed APB offsets.
*/
package sp_pkg;
	// Clock rate of the register side
	localparam int SP_CLK_HZ = 20_000_000;
	// Register byte offsets
	localparam logic [7:0] SP_OFS_DATA   = 8'h00;
	localparam logic [7:0] SP_OFS_STATUS = 8'h04;
	localparam logic [7:0] SP_OFS_CTRL_B = 8'h08;
	localparam logic [7:0] SP_OFS_CTRL_C = 8'h0c;
	localparam logic [7:0] SP_OFS_BAUD   = 8'h10;
	// Status register a bit positions
	localparam int SP_ST_RXC = 7;
	localparam int SP_ST_TXC = 6;
	localparam int SP_ST_TBE = 5;
	localparam int SP_ST_FE  = 4;
	localparam int SP_ST_DOR = 3;
	localparam int SP_ST_PE  = 2;
	// Control register b bit positions
	localparam int SP_CB_RX_COMPLETE_IRQ_ENABLE = 7;
	localparam int SP_CB_TX_COMPLETE_IRQ_ENABLE = 6;
	localparam int SP_CB_TEIE  = 5;
	localparam int SP_CB_RECEIVER_ENABLE  = 4;
	localparam int SP_CB_TRANSMITTER_ENABLE  = 3;
	localparam int SP_CB_SZ2   = 2;
	localparam int SP_CB_RX9   = 1;
	localparam int SP_CB_TX9   = 0;
	// Control register c bit positions
	localparam int SP_CC_SYNC  = 6;
	localparam int SP_CC_PMH   = 5;
	localparam int SP_CC_PML   = 4;
	localparam int SP_CC_STOP2 = 3;
	localparam int SP_CC_SZ1   = 2;
	localparam int SP_CC_SZ0   = 1;
	// Reset values
	localparam logic [7:0]  SP_CTRL_B_RST = 8'h00;
	localparam logic [7:0]  SP_CTRL_C_RST = 8'h06;
	localparam logic [15:0] SP_BAUD_RST   = 16'h000a;
	// Character size code for nine data bits
	localparam logic [2:0]  SP_SZ_NINE    = 3'h7;
	// Transmitter and receiver states
	typedef enum logic [2:0] {
		SP_IDLE, SP_START, SP_DATA, SP_PAR, SP_STOP
	} sp_state_type;

	// Data bits per character from the size field
	function automatic logic [3:0] sp_char_bits(input logic [2:0] size);
		case (size)
			3'h0: sp_char_bits = 4'h5;
			3'h1: sp_char_bits = 4'h6;
			3'h2: sp_char_bits = 4'h7;
			3'h7: sp_char_bits = 4'h9;
			default: sp_char_bits = 4'h8;
		endcase
	endfunction : sp_char_bits

	// Parity over the used data bits, odd inverts
	function automatic logic sp_parity(input logic [8:0] d, input logic [3:0] n,
		input logic odd);
		logic p;
		p = odd;
		for (int i = 0; i < 9; i++) begin
			if (i < int'(n)) begin
				p = p ^ d[i];
			end
		end
		sp_parity = p;
	endfunction : sp_parity
endpackage : sp_pkg

// file: sp_serial_port.sv
/*
 Serial port transmit and receive buffers, flags and interrupt requests
 behind an APB slave. Assumes an external interrupt controller does the
 global masking and pulses the transmit complete acknowledge, and that
 the serial pins come from outside the clock domain.
*/
// Notes on behaviour
// - Buffer empty flag high while holding buffer empty
// - Buffer empty request held while flag set
// - Data register write clears buffer empty flag
// - Transmit complete set after frame, buffer empty
// - Complete flag cleared by service or one
// - Complete request follows flag when enabled
// - Parity inserted after data, before stop
// - Transmitter disable waits until all data sent
// - Receiver enable claims the receive pin
// - Synchronous mode samples on external transfer clock
// - Bits shifted in until first stop bit
// - First stop bit moves frame into buffer
// - Unused upper data bits read zero
// - Ninth received bit shown in control b
// - Errors and ninth bit stored, read advances
// - Receive complete flag shows unread data present
// - Receiver disable flushes the receive buffer
// - Receive request held while flag set
// - Start low, data lsb first, stop high
`timescale 1ns/1ps
`default_nettype none
module sp_serial_port #(
	parameter int RX_DEPTH = 2
) (
	input  wire logic        ref_clk_in,
	input  wire logic        sys_rst_in,
	input  wire logic        psel_in,
	input  wire logic        penable_in,
	input  wire logic        pwrite_in,
	input  wire logic [7:0]  paddr_in,
	input  wire logic [31:0] pwdata_in,
	output logic      [31:0] prdata_out,
	output logic             pready_out,
	output logic             pslverr_out,
	input  wire logic        rxd_in,
	input  wire logic        xck_in,
	input  wire logic        tx_complete_irq_ack_in,
	output logic             txd_out,
	output logic             txd_oe_out,
	output logic             rxd_owned_out,
	output logic             rx_complete_irq_out,
	output logic             tx_empty_irq_out,
	output logic             tx_complete_irq_out
);
	import sp_pkg::*;

	localparam int PW = (RX_DEPTH > 1) ? $clog2(RX_DEPTH) : 1;
	localparam int CW = $clog2(RX_DEPTH + 1);

	// Pointer step with wrap, shared by both fifo ends
	function automatic logic [PW-1:0] next_ptr(input logic [PW-1:0] p);
		next_ptr = (int'(p) == RX_DEPTH - 1) ? '0 : PW'(p + 1'b1);
	endfunction : next_ptr

	logic rxd_s1_q, rxd_s2_q, rxd_s3_q;
	logic xck_s1_q, xck_s2_q, xck_s3_q;
	logic        pready_q, pslverr_q;
	logic [31:0] prdata_q;
	logic rx_complete_irq_enable_q, tx_complete_irq_enable_q, teie_q, receiver_enable_q, transmitter_enable_q, sz2_q, tx9_q;
	logic sync_q, pmh_q, pml_q, stop2_q;
	logic [1:0]  szl_q;
	logic [15:0] baud_q, bcnt_q, rcnt_q;
	sp_state_type tst_q, rst_q;
	logic [8:0]  thr_q, tsh_q, rsh_q;
	logic        thr_full_q, tpar_q, txc_q, ten_q, rpar_q, dor_q;
	logic [3:0]  tidx_q, ridx_q;
	logic        txd_q, txd_oe_q, rx_own_q, rx_irq_q, te_irq_q, tc_irq_q;
	logic [10:0] rx_mem [RX_DEPTH];
	logic [PW-1:0] wptr_q, rptr_q;
	logic [CW-1:0] cnt_q;

	// Two stage synchronisers, third stage only for edges
	always_ff @(posedge ref_clk_in) begin
		rxd_s1_q <= rxd_in;
		rxd_s2_q <= rxd_s1_q;
		rxd_s3_q <= rxd_s2_q;
		xck_s1_q <= xck_in;
		xck_s2_q <= xck_s1_q;
		xck_s3_q <= xck_s2_q;
	end

	// Bus decode
	wire setup    = psel_in & ~penable_in;
	wire access   = psel_in & penable_in & pready_q;
	wire wr_en    = access & pwrite_in;
	wire rd_en    = access & ~pwrite_in;
	wire hit_data = paddr_in == SP_OFS_DATA;
	wire hit_st   = paddr_in == SP_OFS_STATUS;
	wire hit_cb   = paddr_in == SP_OFS_CTRL_B;
	wire hit_cc   = paddr_in == SP_OFS_CTRL_C;
	wire hit_bd   = paddr_in == SP_OFS_BAUD;
	wire mapped   = hit_data | hit_st | hit_cb | hit_cc | hit_bd;

	// Frame format
	wire [2:0]  size  = {sz2_q, szl_q};
	wire [3:0]  nbits = sp_char_bits(size);
	wire [3:0]  last  = nbits - 4'h1;

	// Receive fifo head and flags
	wire        rx_any  = cnt_q != '0;
	wire        rx_full = int'(cnt_q) == RX_DEPTH;
	wire [10:0] head    = rx_any ? rx_mem[rptr_q] : 11'h000;
	wire        rx_complete_flag     = rx_any;
	wire        tbe     = ~thr_full_q;

	// Read data views
	wire [7:0] st_view;
	wire [7:0] cb_view;
	wire [7:0] cc_view;
	assign st_view = {rx_complete_flag, txc_q, tbe, head[9], dor_q, head[10], 2'h0};
	assign cb_view = {rx_complete_irq_enable_q, tx_complete_irq_enable_q, teie_q, receiver_enable_q, transmitter_enable_q, sz2_q,
		head[8], tx9_q};
	assign cc_view = {1'b0, sync_q, pmh_q, pml_q, stop2_q, szl_q, 1'b0};
	wire [31:0] rd_mux = hit_data ? {24'h0, head[7:0]} :
		hit_st ? {24'h0, st_view} :
		hit_cb ? {24'h0, cb_view} :
		hit_cc ? {24'h0, cc_view} :
		hit_bd ? {16'h0, baud_q} : 32'h0;

	// No wait state: answer is built in setup, ready in the first access cycle
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h0;
		end else begin
			pready_q <= setup;
			if (setup) begin
				pslverr_q <= ~mapped;
				prdata_q  <= pwrite_in ? 32'h0 : rd_mux;
			end
		end
	end

	// Control registers; the ninth received bit is read only
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			{rx_complete_irq_enable_q, tx_complete_irq_enable_q, teie_q, receiver_enable_q, transmitter_enable_q, sz2_q} <= SP_CTRL_B_RST[7:2];
			tx9_q  <= SP_CTRL_B_RST[SP_CB_TX9];
			sync_q <= SP_CTRL_C_RST[SP_CC_SYNC];
			{pmh_q, pml_q} <= SP_CTRL_C_RST[SP_CC_PMH:SP_CC_PML];
			stop2_q <= SP_CTRL_C_RST[SP_CC_STOP2];
			szl_q  <= SP_CTRL_C_RST[SP_CC_SZ1:SP_CC_SZ0];
			baud_q <= SP_BAUD_RST;
		end else if (wr_en) begin
			if (hit_cb) begin
				{rx_complete_irq_enable_q, tx_complete_irq_enable_q, teie_q, receiver_enable_q, transmitter_enable_q, sz2_q} <=
					pwdata_in[SP_CB_RX_COMPLETE_IRQ_ENABLE:SP_CB_SZ2];
				tx9_q <= pwdata_in[SP_CB_TX9];
			end
			if (hit_cc) begin
				sync_q  <= pwdata_in[SP_CC_SYNC];
				{pmh_q, pml_q} <= pwdata_in[SP_CC_PMH:SP_CC_PML];
				stop2_q <= pwdata_in[SP_CC_STOP2];
				szl_q   <= pwdata_in[SP_CC_SZ1:SP_CC_SZ0];
			end
			if (hit_bd) begin
				baud_q <= pwdata_in[15:0];
			end
		end
	end

	// Bit clock: internal divider, or transfer clock edges when synchronous
	wire xck_rise = xck_s2_q & ~xck_s3_q;
	wire xck_fall = ~xck_s2_q & xck_s3_q;
	wire btick    = bcnt_q == 16'h0;
	wire ttick    = sync_q ? xck_fall : btick;
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			bcnt_q <= 16'h0;
		end else begin
			bcnt_q <= btick ? baud_q : bcnt_q - 16'h0001;
		end
	end

	// Transmit side control terms
	wire tx_wr    = wr_en & hit_data;
	wire tx_stop  = tst_q == SP_STOP & tidx_q == 4'h0;
	wire tx_ready = tst_q == SP_IDLE | tx_stop;
	wire tx_load  = ten_q & thr_full_q & ttick & tx_ready;
	wire tx_end   = ttick & tx_stop & ~thr_full_q;
	wire txc_clr  = (wr_en & hit_st & pwdata_in[SP_ST_TXC]) | tx_complete_irq_ack_in;
	// Enable stays on until shifter and buffer are both drained
	wire ten_d    = transmitter_enable_q | (ten_q & (thr_full_q | tst_q != SP_IDLE));

	// Holding buffer; a new write wins over the move to the shifter
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			thr_q      <= 9'h000;
			thr_full_q <= 1'b0;
		end else if (tx_wr) begin
			thr_q      <= {tx9_q, pwdata_in[7:0]};
			thr_full_q <= 1'b1;
		end else if (tx_load) begin
			thr_full_q <= 1'b0;
		end
	end

	// Transmit shifter
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			tst_q  <= SP_IDLE;
			tsh_q  <= 9'h000;
			tidx_q <= 4'h0;
			tpar_q <= 1'b0;
		end else if (tx_load) begin
			tst_q  <= SP_START;
			tsh_q  <= thr_q;
			tpar_q <= sp_parity(thr_q, nbits, pml_q);
		end else if (ttick) begin
			case (tst_q)
				SP_START: begin
					tst_q  <= SP_DATA;
					tidx_q <= 4'h0;
				end
				SP_DATA: begin
					if (tidx_q == last) begin
						tst_q  <= pmh_q ? SP_PAR : SP_STOP;
						tidx_q <= {3'h0, stop2_q};
					end else begin
						tidx_q <= tidx_q + 4'h1;
					end
				end
				SP_PAR: begin
					tst_q  <= SP_STOP;
					tidx_q <= {3'h0, stop2_q};
				end
				SP_STOP: begin
					if (tidx_q != 4'h0) begin
						tidx_q <= 4'h0;
					end else begin
						tst_q <= SP_IDLE;
					end
				end
				default: tst_q <= SP_IDLE;
			endcase
		end
	end

	// Line level per state, low start and high stop
	wire txd_d = (tst_q == SP_START) ? 1'b0 :
		(tst_q == SP_DATA) ? tsh_q[tidx_q] :
		(tst_q == SP_PAR) ? tpar_q : 1'b1;

	// Transmit complete flag; a new completion beats a clear
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			txc_q <= 1'b0;
			ten_q <= 1'b0;
		end else begin
			ten_q <= ten_d;
			if (tx_end) begin
				txc_q <= 1'b1;
			end else if (txc_clr) begin
				txc_q <= 1'b0;
			end
		end
	end

	// Receive sampling point
	wire rfall   = ~rxd_s2_q & rxd_s3_q;
	wire rsample = sync_q ? xck_rise :
		(rst_q != SP_IDLE & rcnt_q == 16'h0);
	wire rx_pop  = rd_en & hit_data & rx_any;
	wire rx_done = rsample & rst_q == SP_STOP;
	wire rx_push = rx_done & ~rx_full;
	wire rpe     = pmh_q & (sp_parity(rsh_q, nbits, pml_q) != rpar_q);
	wire rlast   = ridx_q == last;

	// Receive shifter; disable drops any frame in flight
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in | ~receiver_enable_q) begin
			rst_q  <= SP_IDLE;
			rcnt_q <= 16'h0;
			rsh_q  <= 9'h000;
			ridx_q <= 4'h0;
			rpar_q <= 1'b0;
		end else begin
			rcnt_q <= (rcnt_q == 16'h0) ? baud_q : rcnt_q - 16'h0001;
			case (rst_q)
				SP_IDLE: begin
					rsh_q  <= 9'h000;
					ridx_q <= 4'h0;
					if (sync_q & xck_rise & ~rxd_s2_q) begin
						rst_q <= SP_DATA;
					end else if (~sync_q & rfall) begin
						rst_q  <= SP_START;
						rcnt_q <= {1'b0, baud_q[15:1]};     // Aim at mid bit
					end
				end
				SP_START: begin
					if (rsample) begin
						rst_q <= rxd_s2_q ? SP_IDLE : SP_DATA;
					end
				end
				SP_DATA: begin
					if (rsample) begin
						rsh_q[ridx_q] <= rxd_s2_q;
						ridx_q <= ridx_q + 4'h1;
						if (rlast) begin
							rst_q <= pmh_q ? SP_PAR : SP_STOP;
						end
					end
				end
				SP_PAR: begin
					if (rsample) begin
						rpar_q <= rxd_s2_q;
						rst_q  <= SP_STOP;
					end
				end
				SP_STOP: begin
					if (rsample) begin
						rst_q <= SP_IDLE;
					end
				end
				default: rst_q <= SP_IDLE;
			endcase
		end
	end

	// Receive fifo with per frame status; disable flushes it
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in | ~receiver_enable_q) begin
			wptr_q <= '0;
			rptr_q <= '0;
			cnt_q  <= '0;
			dor_q  <= 1'b0;
		end else begin
			if (rx_push) begin
				rx_mem[wptr_q] <= {rpe, ~rxd_s2_q, rsh_q};
				wptr_q <= next_ptr(wptr_q);
				dor_q  <= 1'b0;
			end else if (rx_done) begin
				dor_q <= 1'b1;
			end
			if (rx_pop) begin
				rptr_q <= next_ptr(rptr_q);
			end
			if (rx_push & ~rx_pop) begin
				cnt_q <= cnt_q + 1'b1;
			end else if (rx_pop & ~rx_push) begin
				cnt_q <= cnt_q - 1'b1;
			end
		end
	end

	// Pin ownership and level interrupt requests
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			txd_q    <= 1'b1;
			txd_oe_q <= 1'b0;
			rx_own_q <= 1'b0;
			rx_irq_q <= 1'b0;
			te_irq_q <= 1'b0;
			tc_irq_q <= 1'b0;
		end else begin
			txd_q    <= txd_d;
			txd_oe_q <= ten_d;
			rx_own_q <= receiver_enable_q;
			rx_irq_q <= rx_complete_irq_enable_q & rx_complete_flag;
			te_irq_q <= teie_q & tbe;
			tc_irq_q <= tx_complete_irq_enable_q & txc_q & ~txc_clr;
		end
	end

	assign prdata_out          = prdata_q;
	assign pready_out          = pready_q;
	assign pslverr_out         = pslverr_q;
	assign txd_out             = txd_q;
	assign txd_oe_out          = txd_oe_q;
	assign rxd_owned_out       = rx_own_q;
	assign rx_complete_irq_out = rx_irq_q;
	assign tx_empty_irq_out    = te_irq_q;
	assign tx_complete_irq_out = tc_irq_q;
endmodule : sp_serial_port
`default_nettype wire

// file: sp_serial_port_assertions.sv
/*
 Port-level checker of the serial port block, bound into sp_serial_port.
 Assumes the sp_pkg register map and one clock with synchronous reset.
*/
`timescale 1ns/1ps
`default_nettype none
module sp_serial_port_checker
	import sp_pkg::*;
#(
	parameter int RX_DEPTH = 2
) (
	input wire logic        ref_clk_in,
	input wire logic        sys_rst_in,
	input wire logic        psel_in,
	input wire logic        penable_in,
	input wire logic        pwrite_in,
	input wire logic [7:0]  paddr_in,
	input wire logic [31:0] pwdata_in,
	input wire logic        pready_out,
	input wire logic        pslverr_out,
	input wire logic        tx_complete_irq_ack_in,
	input wire logic        txd_out,
	input wire logic        txd_oe_out,
	input wire logic        rxd_owned_out,
	input wire logic        rx_complete_irq_out,
	input wire logic        tx_empty_irq_out,
	input wire logic        tx_complete_irq_out
);
	logic [7:0] cb_q;
	logic       wr;
	// Completed write, the edge where a register changes
	assign wr = psel_in && penable_in && pready_out && pwrite_in;
	// Shadow of control b, so enables can be judged from the pins
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			cb_q <= 8'h00;
		end else if (wr && paddr_in == SP_OFS_CTRL_B) begin
			cb_q <= pwdata_in[7:0];
		end
	end
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (sys_rst_in);
	apb_ready_a: assert property (psel_in && !penable_in |=> pready_out)
		else $error("no ready in access cycle");
	apb_unmapped_a: assert property (psel_in && !penable_in && paddr_in > SP_OFS_BAUD
		|=> pslverr_out) else $error("unmapped access not refused");
	empty_gate_a: assert property (
		!cb_q[SP_CB_TEIE] && !$past(cb_q[SP_CB_TEIE]) |-> !tx_empty_irq_out)
		else $error("empty request while disabled");
	done_gate_a: assert property (
		!cb_q[SP_CB_TX_COMPLETE_IRQ_ENABLE] && !$past(cb_q[SP_CB_TX_COMPLETE_IRQ_ENABLE]) |-> !tx_complete_irq_out)
		else $error("complete request while disabled");
	rx_flush_a: assert property (!cb_q[SP_CB_RECEIVER_ENABLE] [*3] |-> !rx_complete_irq_out)
		else $error("receive request while receiver off");
	rx_owner_a: assert property (rxd_owned_out == cb_q[SP_CB_RECEIVER_ENABLE]
		|| rxd_owned_out == $past(cb_q[SP_CB_RECEIVER_ENABLE])) else $error("pin owner wrong");
	txd_idle_a: assert property (!txd_oe_out |-> txd_out)
		else $error("released pin not idle");
	w1c_done_a: assert property (
		wr && paddr_in == SP_OFS_STATUS && pwdata_in[SP_ST_TXC] |=> !tx_complete_irq_out)
		else $error("write one did not clear complete");
	ack_done_a: assert property (tx_complete_irq_ack_in |=> !tx_complete_irq_out)
		else $error("service did not clear complete");
	data_clear_a: assert property (
		wr && paddr_in == SP_OFS_DATA |-> ##[1:2] !tx_empty_irq_out)
		else $error("data write left empty request");
	cover property ($rose(tx_complete_irq_out));
	cover property ($rose(rx_complete_irq_out));
	cover property (pslverr_out);
endmodule : sp_serial_port_checker
bind sp_serial_port sp_serial_port_checker #(.RX_DEPTH(RX_DEPTH)) chk (
	.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .psel_in(psel_in),
	.penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
	.pwdata_in(pwdata_in), .pready_out(pready_out), .pslverr_out(pslverr_out),
	.tx_complete_irq_ack_in(tx_complete_irq_ack_in), .txd_out(txd_out),
	.txd_oe_out(txd_oe_out), .rxd_owned_out(rxd_owned_out),
	.rx_complete_irq_out(rx_complete_irq_out), .tx_empty_irq_out(tx_empty_irq_out),
	.tx_complete_irq_out(tx_complete_irq_out));
`default_nettype wire

// file: sp_remote_peer.sv
/*
 Behavioural remote serial device on the data lines.
 Assumes a bit lasts BIT system clocks; the line idles high (pull-up).
*/
`timescale 1ns/1ps
`default_nettype none
module sp_remote_peer #(
	parameter int BIT = 4
) (
	input  wire logic ref_clk_in,
	input  wire logic txd_in,
	output logic      rxd_out,
	output logic      xck_out
);
	initial rxd_out = 1'b1;
	initial xck_out = 1'b0;
	// Synchronous frame: data set while clock low, clock stands still when idle
	task automatic send_sync(input logic [11:0] bits, input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge ref_clk_in);
			rxd_out <= bits[i];
			xck_out <= 1'b0;
			repeat (3) @(posedge ref_clk_in);
			xck_out <= 1'b1;
			repeat (3) @(posedge ref_clk_in);
		end
		@(posedge ref_clk_in);
		rxd_out <= 1'b1;
		xck_out <= 1'b0;
	endtask : send_sync
	// Frame bits include start and stop, sent lsb first, then back to idle
	task automatic send(input logic [11:0] bits, input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge ref_clk_in);
			rxd_out <= bits[i];
			repeat (BIT - 1) @(posedge ref_clk_in);
		end
		@(posedge ref_clk_in);
		rxd_out <= 1'b1;
	endtask : send
	// Waits for a start edge, bounded; samples mid-bit; zeros on timeout
	task automatic grab(output logic [11:0] bits, input int n);
		int k;
		bits = 12'h000;
		k = 0;
		while (txd_in !== 1'b0 && k < 400) begin
			@(posedge ref_clk_in);
			k++;
		end
		if (k < 400) begin
			repeat (BIT / 2) @(posedge ref_clk_in);
			for (int i = 0; i < n; i++) begin
				bits[i] = txd_in;
				// Stop after the last sample so a back to back start is seen
				if (i < n - 1) begin
					repeat (BIT) @(posedge ref_clk_in);
				end
			end
		end
	endtask : grab
endmodule : sp_remote_peer
`default_nettype wire

// file: sp_serial_port_test.sv
/*
 Self-checking testbench of the serial port block with a remote peer.
 Assumes baud divisor 3, so one bit lasts four system clocks.
*/
`timescale 1ns/1ps
`default_nettype none
module sp_serial_port_test;
	import sp_pkg::*;
	localparam int BIT = 4;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic        ack = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rdv;
	logic        pready, pslverr, errv, rxd, txd, oe, owned, rx_irq, te_irq, tc_irq;
	logic        external_transfer_clock;
	int          bad_count = 0;
	int          checks = 0;
	// Free running system clock
	always #25 clk = ~clk;
	sp_serial_port #(.RX_DEPTH(2)) dut (
		.ref_clk_in(clk), .sys_rst_in(rst), .psel_in(psel), .penable_in(penable),
		.pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
		.pready_out(pready), .pslverr_out(pslverr), .rxd_in(rxd), .xck_in(external_transfer_clock),
		.tx_complete_irq_ack_in(ack), .txd_out(txd), .txd_oe_out(oe),
		.rxd_owned_out(owned), .rx_complete_irq_out(rx_irq),
		.tx_empty_irq_out(te_irq), .tx_complete_irq_out(tc_irq));
	sp_remote_peer #(.BIT(BIT)) peer (.ref_clk_in(clk), .txd_in(txd), .rxd_out(rxd),
		.xck_out(external_transfer_clock));
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	// One APB transfer; request held until ready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		// A slave that never answers counts as a mismatch
		if (pready !== 1'b1) begin
			bad_count++;
		end
		rdv = prdata;
		errv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk($sformatf("reg %h", a), rdv, e);
	endtask : rd
	task automatic t_reset();
		rd(SP_OFS_STATUS, 32'h20);
		rd(SP_OFS_CTRL_B, 32'h00);
		apb(1'b0, 8'h14, 32'h0);
		chk("slverr", {31'h0, errv}, 32'h1);
	endtask : t_reset
	task automatic t_tx();
		logic [11:0] f;
		wr(SP_OFS_BAUD, 32'h3);
		wr(SP_OFS_CTRL_C, 32'h26);
		wr(SP_OFS_CTRL_B, 32'h68);
		repeat (3) @(posedge clk);
		chk("empty_irq", {31'h0, te_irq}, 32'h1);
		chk("done_irq", {31'h0, tc_irq}, 32'h0);
		fork
			peer.grab(f, 11);
			begin
				wr(SP_OFS_DATA, 32'ha5);
				repeat (8) @(posedge clk);
				wr(SP_OFS_DATA, 32'h07);
				rd(SP_OFS_STATUS, 32'h00);
			end
		join
		chk("frame a", {20'h0, f}, {21'h1, 1'b0, 8'ha5, 1'b0});
		peer.grab(f, 11);
		chk("frame b", {20'h0, f}, {21'h1, 1'b1, 8'h07, 1'b0});
		repeat (2 * BIT) @(posedge clk);
		rd(SP_OFS_STATUS, 32'h60);
		chk("done_irq", {31'h0, tc_irq}, 32'h1);
		ack <= 1'b1;
		@(posedge clk);
		ack <= 1'b0;
		repeat (2) @(posedge clk);
		chk("done_irq", {31'h0, tc_irq}, 32'h0);
		rd(SP_OFS_STATUS, 32'h20);
	endtask : t_tx
	task automatic t_txoff();
		wr(SP_OFS_CTRL_B, 32'h0d);
		wr(SP_OFS_DATA, 32'h11);
		repeat (8) @(posedge clk);
		wr(SP_OFS_DATA, 32'h22);
		wr(SP_OFS_CTRL_B, 32'h00);
		repeat (30) @(posedge clk);
		chk("txd_oe", {31'h0, oe}, 32'h1);
		repeat (70) @(posedge clk);
		chk("txd_oe", {31'h0, oe}, 32'h0);
		wr(SP_OFS_STATUS, 32'h00);
		rd(SP_OFS_STATUS, 32'h60);
		wr(SP_OFS_STATUS, 32'h40);
		rd(SP_OFS_STATUS, 32'h20);
	endtask : t_txoff
	task automatic t_rx();
		wr(SP_OFS_CTRL_C, 32'h06);
		wr(SP_OFS_CTRL_B, 32'h94);
		repeat (2) @(posedge clk);
		chk("rxd_owned", {31'h0, owned}, 32'h1);
		peer.send({2'b01, 9'h13c, 1'b0}, 11);
		repeat (BIT) @(posedge clk);
		chk("rx_irq", {31'h0, rx_irq}, 32'h1);
		peer.send({2'b00, 9'h0c3, 1'b0}, 11);
		repeat (BIT) @(posedge clk);
		rd(SP_OFS_STATUS, 32'ha0);
		rd(SP_OFS_CTRL_B, 32'h96);
		rd(SP_OFS_DATA, 32'h3c);
		chk("rx_irq", {31'h0, rx_irq}, 32'h1);
		rd(SP_OFS_STATUS, 32'hb0);
		rd(SP_OFS_CTRL_B, 32'h94);
		rd(SP_OFS_DATA, 32'hc3);
		repeat (2) @(posedge clk);
		chk("rx_irq", {31'h0, rx_irq}, 32'h0);
		rd(SP_OFS_STATUS, 32'h20);
	endtask : t_rx
	task automatic t_sync();
		wr(SP_OFS_CTRL_C, 32'h46);
		wr(SP_OFS_CTRL_B, 32'h90);
		peer.send_sync({2'b00, 1'b1, 8'h5a, 1'b0}, 10);
		repeat (BIT) @(posedge clk);
		rd(SP_OFS_DATA, 32'h5a);
	endtask : t_sync
	task automatic t_flush();
		wr(SP_OFS_CTRL_C, 32'h04);
		wr(SP_OFS_CTRL_B, 32'h90);
		peer.send({4'b0001, 7'h7f, 1'b0}, 9);
		repeat (BIT) @(posedge clk);
		rd(SP_OFS_DATA, 32'h7f);
		peer.send({4'b0001, 7'h2a, 1'b0}, 9);
		repeat (BIT) @(posedge clk);
		wr(SP_OFS_CTRL_B, 32'h00);
		rd(SP_OFS_STATUS, 32'h20);
		chk("rxd_owned", {31'h0, owned}, 32'h0);
		chk("rx_irq", {31'h0, rx_irq}, 32'h0);
	endtask : t_flush
	task automatic wrap_up();
		$display("checks %0d bad_count %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : wrap_up
	// Main sequence after five reset cycles
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_tx();
		t_txoff();
		t_rx();
		t_sync();
		t_flush();
		wrap_up();
	end
	// Watchdog well beyond the several hundred cycles the run needs
	initial begin
		repeat (20000) @(posedge clk);
		bad_count++;
		wrap_up();
	end
endmodule : sp_serial_port_test
`default_nettype wire
